//--- src/sarc_consts.svh
// Constants for the serial converter readout control block.
// Assumes the including file runs on the 200 MHz system clock.
`ifndef SARC_CONSTS_SVH
`define SARC_CONSTS_SVH

// ************************************************************
// Timing
// ************************************************************
`define SARC_CLK_PERIOD_NS 5
// Internal conversion period; chosen default, no printed figure
`define SARC_CONV_TIME_NS 8000
// Least time, so round up
`define SARC_CONV_CYCLES \
  ((`SARC_CONV_TIME_NS + `SARC_CLK_PERIOD_NS - 1) / `SARC_CLK_PERIOD_NS)

// ************************************************************
// Result format
// ************************************************************
`define SARC_RESULT_BITS 12
`define SARC_BUF_DEPTH 2

// ************************************************************
// Pin bundle field positions
// ************************************************************
`define SARC_PIN_PD_LSB 0
`define SARC_PIN_SCLK 2
`define SARC_PIN_CS_N 3

// ************************************************************
// Reset values
// ************************************************************
`define SARC_PINS_RESET 4'h8
`define SARC_DOUT_RESET 1'h0

`endif

//--- src/sarc_pkg.sv
// Types shared by the readout control block and its buffer.
// Assumes sarc_consts.svh is on the include path.
`include "sarc_consts.svh"

package sarc_pkg;

  // Three-level power-down pin, resolved by the pad into two bits
  typedef enum logic [1:0] {
    SARC_PD_LOW   = 2'h0,
    SARC_PD_FLOAT = 2'h1,
    SARC_PD_HIGH  = 2'h3
  } sarc_pd_e;

  typedef enum logic [5:0] {
    SARC_SHUT  = 6'h01,
    SARC_IDLE  = 6'h02,
    SARC_CONV  = 6'h04,
    SARC_LOAD  = 6'h08,
    SARC_EOC   = 6'h10,
    SARC_SHIFT = 6'h20
  } sarc_state_e;

  // Pins that arrive from outside the clock domain
  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [1:0] pd;
  } sarc_pins_s;

  typedef logic [`SARC_RESULT_BITS-1:0] sarc_word_t;

endpackage

//--- src/sarc_buf.sv
// Small FIFO with valid/ready on both sides and a flush.
// Assumes one clock, synchronous active-high reset, DEPTH a power of 2.
`include "sarc_consts.svh"

module sarc_buf
  import sarc_pkg::*;
#(
  parameter int W     = `SARC_RESULT_BITS,
  parameter int DEPTH = `SARC_BUF_DEPTH
)
(
  input  wire logic         i_clock,
  input  wire logic         i_reset,
  input  wire logic         i_flush,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem      [DEPTH];
  logic [W-1:0] next_mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0]   next_count;
  logic          push;
  logic          pop;

  assign o_in_ready  = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb
  begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push)
    begin
      next_mem[wr_ptr] = i_in_data;
      next_wr_ptr      = wr_ptr + 1'b1;
    end
    if (pop)
      next_rd_ptr = rd_ptr + 1'b1;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
    // Flush drops stale words, a push in the same cycle included
    if (i_flush)
    begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
  end

  always_ff @(posedge i_clock)
  begin
    mem <= next_mem;
    if (i_reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

endmodule

//--- src/sarc_top.sv
// Control and 3-wire serial readout of a 12-bit converter.
// Assumes chip select, serial clock and power-down pins are asynchronous,
// the sample word is on the system clock, and a pad resolves the data pin.
//
// Behaviour
// [RULE_01] Chip-select falling edge starts a new conversion.
// [RULE_02] Data pin is high impedance while chip select is high.
// [RULE_03] Data pin changes only on serial-clock falling edges.
// [RULE_04] Power-down pin low enters shutdown and stops conversions.
// [RULE_05] Power-down pin high or floating keeps the device operational.
// [RULE_06] Reference enabled when pin high, disabled when it floats.
// [RULE_07] Host keeps chip select high at least 1.5 us between frames.
// [RULE_08] Host runs serial clock no faster than 2.1 MHz; the bench host runs it at 12.5 MHz.
// [RULE_09] Result is a high end-of-conversion bit then 12 bits MSB first.
// [RULE_10] Data goes low at chip-select fall; host holds clock low meanwhile.
// [RULE_11] Data rises high when the internal conversion completes.
`include "sarc_consts.svh"

module sarc_top
  import sarc_pkg::*;
#(
  parameter int CONV_CYCLES = `SARC_CONV_CYCLES
)
(
  input  wire logic                         I_CLOCK,
  input  wire logic                         I_RESET,
  input  wire logic                         I_CS_N,
  input  wire logic                         I_SCLK,
  input  wire logic [1:0]                   I_POWER_DOWN_SELECT,
  input  wire logic [`SARC_RESULT_BITS-1:0] I_ANALOG_SAMPLE_INPUT,
  output logic                              O_DOUT,
  output logic                              O_DOUT_OE_N,
  output logic                              O_REF_ENABLE,
  output logic                              O_LOW_POWER,
  output logic                              O_CONVERTING
);

  localparam int NB = `SARC_RESULT_BITS;
  localparam int TW = (CONV_CYCLES > 1) ? $clog2(CONV_CYCLES) : 1;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  sarc_pins_s pin_s1;
  sarc_pins_s pin_s2;
  sarc_pins_s pin_s3;
  sarc_pins_s pins;
  sarc_pins_s pins_prev;
  sarc_pins_s next_pins;
  sarc_pins_s raw_pins;

  always_comb
  begin
    raw_pins.cs_n = I_CS_N;
    raw_pins.sclk = I_SCLK;
    raw_pins.pd   = I_POWER_DOWN_SELECT;
    // A bit moves only once stages two and three agree
    next_pins = sarc_pins_s'((pin_s2 & pin_s3) | (pins & (pin_s2 ^ pin_s3)));
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      pin_s1    <= sarc_pins_s'(`SARC_PINS_RESET);
      pin_s2    <= sarc_pins_s'(`SARC_PINS_RESET);
      pin_s3    <= sarc_pins_s'(`SARC_PINS_RESET);
      pins      <= sarc_pins_s'(`SARC_PINS_RESET);
      pins_prev <= sarc_pins_s'(`SARC_PINS_RESET);
    end
    else
    begin
      pin_s1    <= raw_pins;
      pin_s2    <= pin_s1;
      pin_s3    <= pin_s2;
      pins      <= next_pins;
      pins_prev <= pins;
    end
  end

  logic cs_fall;
  logic sclk_fall;
  logic pd_low;

  assign cs_fall   = pins_prev.cs_n && !pins.cs_n;
  assign sclk_fall = pins_prev.sclk && !pins.sclk;
  assign pd_low    = (pins.pd == SARC_PD_LOW);

  // ************************************************************
  // Result buffer
  // ************************************************************
  sarc_word_t hold;
  sarc_word_t buf_data;
  logic       buf_in_valid;
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic       buf_out_ready;
  logic       buf_flush;

  sarc_buf #(
    .W     (NB),
    .DEPTH (`SARC_BUF_DEPTH)
  ) u_buf (
    .i_clock     (I_CLOCK),
    .i_reset     (I_RESET),
    .i_flush     (buf_flush),
    .i_in_valid  (buf_in_valid),
    .o_in_ready  (buf_in_ready),
    .i_in_data   (hold),
    .o_out_valid (buf_out_valid),
    .i_out_ready (buf_out_ready),
    .o_out_data  (buf_data)
  );

  // ************************************************************
  // Conversion and readout sequencer
  // ************************************************************
  sarc_state_e state;
  sarc_state_e next_state;
  logic [TW-1:0] timer;
  logic [TW-1:0] next_timer;
  sarc_word_t    next_hold;
  sarc_word_t    shreg;
  sarc_word_t    next_shreg;
  logic          dout;
  logic          next_dout;

  always_comb
  begin
    next_state    = state;
    next_timer    = timer;
    next_hold     = hold;
    next_shreg    = shreg;
    next_dout     = dout;
    buf_in_valid  = 1'b0;
    buf_out_ready = 1'b0;
    buf_flush     = 1'b0;
    unique case (state)
      SARC_SHUT:
      begin
        // Leaving shutdown goes to idle, so converting needs a fresh chip-select fall
        if (!pd_low)
          next_state = SARC_IDLE; // [RULE_05]
      end
      SARC_IDLE:
      begin
        if (cs_fall)
        begin
          next_state = SARC_CONV; // [RULE_01]
          next_hold  = I_ANALOG_SAMPLE_INPUT;
          next_timer = TW'(CONV_CYCLES - 1);
          next_dout  = 1'b0; // [RULE_10]
        end
      end
      SARC_CONV:
      begin
        if (timer != '0)
          next_timer = timer - 1'b1;
        else
        begin
          // A full buffer holds the conversion here
          buf_in_valid = 1'b1;
          if (buf_in_ready)
            next_state = SARC_LOAD;
        end
      end
      SARC_LOAD:
      begin
        buf_out_ready = 1'b1;
        if (buf_out_valid)
        begin
          next_shreg = buf_data;
          next_dout  = 1'b1; // [RULE_11] [RULE_09]
          next_state = SARC_EOC;
        end
      end
      SARC_EOC, SARC_SHIFT:
      begin
        if (sclk_fall)
        begin
          next_dout  = shreg[NB-1]; // [RULE_03] [RULE_09]
          next_shreg = {shreg[NB-2:0], 1'b0};
          next_state = SARC_SHIFT;
        end
      end
    endcase
    // Chip select rising aborts any frame
    if (pins.cs_n && state != SARC_IDLE && state != SARC_SHUT)
    begin
      next_state = SARC_IDLE; // [RULE_02]
      buf_flush  = 1'b1;
    end
    if (pd_low)
    begin
      next_state = SARC_SHUT; // [RULE_04]
      buf_flush  = 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      state <= SARC_IDLE;
      timer <= '0;
      hold  <= '0;
      shreg <= '0;
      dout  <= `SARC_DOUT_RESET;
    end
    else
    begin
      state <= next_state;
      timer <= next_timer;
      hold  <= next_hold;
      shreg <= next_shreg;
      dout  <= next_dout;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  logic ref_en;
  logic next_ref_en;

  // Floating pin frees the reference pin for an external source
  assign next_ref_en = (pins.pd == SARC_PD_HIGH); // [RULE_06]

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
      ref_en <= 1'b0;
    else
      ref_en <= next_ref_en;
  end

  assign O_DOUT       = dout;
  assign O_DOUT_OE_N  = (state == SARC_IDLE) || (state == SARC_SHUT); // [RULE_02]
  assign O_REF_ENABLE = ref_en;
  assign O_LOW_POWER  = (state == SARC_SHUT); // [RULE_04]
  assign O_CONVERTING = (state == SARC_CONV) || (state == SARC_LOAD);

endmodule

//--- sim/sarc_top_chk.sv
// Pin-level assertions for the readout block.
// Assumes the link pins move away from system clock edges.
module sarc_top_chk
  import sarc_pkg::*;
#(
  parameter int CONV_CYCLES = 20
)
(
  input wire logic       I_CLOCK,
  input wire logic       I_RESET,
  input wire logic       I_CS_N,
  input wire logic       I_SCLK,
  input wire logic [1:0] I_POWER_DOWN_SELECT,
  input wire logic       O_DOUT,
  input wire logic       O_DOUT_OE_N,
  input wire logic       O_REF_ENABLE,
  input wire logic       O_LOW_POWER,
  input wire logic       O_CONVERTING
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********
  // Helpers
  // ********
  // Window allows three extra clocks for a full-buffer stall
  localparam int LO = CONV_CYCLES - 6;
  localparam int HI = CONV_CYCLES - 3;
  logic       sclk_q;
  logic [3:0] since_fall;
  logic       eoc_seen;
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);
  always_ff @(posedge I_CLOCK)
  begin
    sclk_q <= I_SCLK;
    if (I_RESET)
      since_fall <= 4'hF;
    else if (sclk_q && !I_SCLK)
      since_fall <= 4'h0;
    else if (since_fall != 4'hF)
      since_fall <= since_fall + 4'h1;
    if (I_RESET || O_DOUT_OE_N)
      eoc_seen <= 1'b0;
    else if (O_DOUT)
      eoc_seen <= 1'b1;
  end
  // ********
  // Checks
  // ********
  a_oe_cs_high: assert property (
    I_CS_N [*8] |-> O_DOUT_OE_N)
    else $error("data pin driven while deselected");
  a_cs_rise_off: assert property (
    $rose(I_CS_N) |-> ##[3:8] O_DOUT_OE_N)
    else $error("data pin not released after deselect");
  a_conv_start: assert property (
    $fell(I_CS_N) && O_DOUT_OE_N && !O_LOW_POWER
    && I_POWER_DOWN_SELECT != 2'h0
    |-> ##[3:7] (!O_DOUT_OE_N && !O_DOUT && O_CONVERTING))
    else $error("select fall did not start a conversion");
  a_eoc_time: assert property (
    $rose(O_CONVERTING) |-> (!O_DOUT && !O_DOUT_OE_N) [*8]
    ##[LO:HI] $rose(O_DOUT))
    else $error("end of conversion late or early");
  a_shut_pd: assert property (
    (I_POWER_DOWN_SELECT == 2'h0) [*8]
    |-> O_LOW_POWER && O_DOUT_OE_N && !O_CONVERTING)
    else $error("power-down pin low without shutdown");
  a_oper_pd: assert property (
    (I_POWER_DOWN_SELECT != 2'h0) [*8] |-> ##2 !O_LOW_POWER)
    else $error("shutdown while power-down pin not low");
  a_ref_level: assert property (
    $stable(I_POWER_DOWN_SELECT) [*8]
    |-> O_REF_ENABLE == (I_POWER_DOWN_SELECT == 2'h3))
    else $error("reference enable wrong for pin level");
  a_dout_on_fall: assert property (
    $changed(O_DOUT) && !O_DOUT_OE_N && !$past(O_DOUT_OE_N) && eoc_seen
    |-> since_fall < 4'h9)
    else $error("data changed away from a clock fall");
endmodule

bind sarc_top sarc_top_chk #(.CONV_CYCLES(CONV_CYCLES)) chk (
  .I_CLOCK, .I_RESET, .I_CS_N, .I_SCLK, .I_POWER_DOWN_SELECT,
  .O_DOUT, .O_DOUT_OE_N, .O_REF_ENABLE, .O_LOW_POWER, .O_CONVERTING);

//--- sim/sarc_host.sv
// Serial master model on the 3-wire link.
// Assumes it is the only driver of chip select and serial clock.
module sarc_host
#(
  parameter int HALF = 40
)
(
  input  wire logic   i_clock,
  input  wire logic   i_dout,
  input  wire logic   i_dout_oe_n,
  output logic        o_cs_n = 1'b1,
  output logic        o_sclk = 1'b0,
  output logic [12:0] o_word = 13'h0,
  output logic        o_seen = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********
  // Link
  // ********
  logic last = 1'b0;
  logic pin;
  // Released line shows the inverse, never a kind leftover value
  assign pin = i_dout_oe_n ? ~last : i_dout;
  always @(posedge i_clock)
    if (!i_dout_oe_n)
      last <= i_dout;
  task automatic frame(input logic read);
    int n;
    n = 0;
    #1501;
    o_cs_n = 1'b0;
    // Clock held low until the end-of-conversion bit shows
    do
    begin
      #HALF;
      n++;
    end
    while (read && pin !== 1'b1 && n < 100);
    for (int i = 0; read && i < 13; i++)
    begin
      o_sclk = 1'b1;
      o_word = {o_word[11:0], pin};
      #HALF;
      o_sclk = 1'b0;
      #HALF;
    end
    o_cs_n = 1'b1;
    if (read)
      o_seen = ~o_seen;
  endtask
endmodule

//--- sim/sarc_top_tb.sv
// Self-checking bench for the converter readout block.
// Assumes the host model drives the link at its own timing.
module sarc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ********
  // Setup
  // ********
  localparam int CONV = 20;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic [1:0]           pd = 2'h3;
  sarc_pkg::sarc_word_t smp = 12'h000;
  logic                 cs_n, sclk, dout, oe_n, ref_en, low_pw, seen;
  logic                 conv;
  logic [12:0]          word;
  logic [12:0]          expq[$];
  logic [1:0]           modes[3] = '{2'h1, 2'h2, 2'h3};
  int                   miscompares = 0;
  int                   check_count = 0;
  int                   cyc = 0;
  sarc_top #(.CONV_CYCLES(CONV)) uut (
    .I_CLOCK(clk), .I_RESET(rst), .I_CS_N(cs_n), .I_SCLK(sclk),
    .I_POWER_DOWN_SELECT(pd), .I_ANALOG_SAMPLE_INPUT(smp),
    .O_DOUT(dout), .O_DOUT_OE_N(oe_n), .O_REF_ENABLE(ref_en),
    .O_LOW_POWER(low_pw), .O_CONVERTING(conv));
  sarc_host host (.i_clock(clk), .i_dout(dout), .i_dout_oe_n(oe_n),
    .o_cs_n(cs_n), .o_sclk(sclk), .o_word(word), .o_seen(seen));
  initial
    forever #2.5 clk = ~clk;
  task automatic check(input logic [12:0] got, input logic [12:0] want);
    check_count++;
    if (got !== want)
    begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ********
  // Tests
  // ********
  task automatic read_one(input logic [1:0] m, input logic [11:0] v);
    @(posedge clk);
    pd <= m;
    smp <= v;
    repeat (16) @(posedge clk);
    check(13'(ref_en), 13'(m == 2'h3));
    check(13'(low_pw), 13'h0);
    expq.push_back({1'b1, v});
    host.frame(1'b1);
    $display("test frame %h done", v);
  endtask
  // Guard skips the time-zero settle of the toggle line
  always @(seen)
    if (rst === 1'b0)
      check(word, expq.pop_front());
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  initial
  begin
    void'($urandom(32'h249C0CBA));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (16) @(posedge clk);
    read_one(2'h3, 12'hFFF);
    read_one(2'h1, 12'h000);
    for (int i = 0; i < 6; i++)
      read_one(modes[i % 3], 12'($urandom));
    // A select pulse in shutdown must yield no word
    @(posedge clk);
    pd <= 2'h0;
    repeat (16) @(posedge clk);
    check(13'(low_pw), 13'h1);
    fork
      host.frame(1'b0);
      begin
        wait (cs_n === 1'b0);
        repeat (7) @(posedge clk);
        check(13'(oe_n), 13'h1);
        check(13'(conv), 13'h0);
      end
    join
    $display("test shutdown done");
    read_one(2'h3, 12'($urandom));
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule
